// ---- core/gpr_mem.sv ----
// Purpose: General-purpose register storage with registered read data.
// Assumes: Single clock, one read and one write port.
// Notes:   Contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module gpr_mem #(
  parameter int DEPTH = 188,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (int'(raddr_i) < DEPTH) begin
      rdata_o <= mem_reg[raddr_i];
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- core/port_regfile_pkg.sv ----
// Purpose: Shared constants for the port and register file block.
// Assumes: One 10 MHz system clock.
// Notes:   Addresses are register file locations, not byte offsets.
package port_regfile_pkg;
  localparam logic [7:0]  PORT0_ADDR       = 8'h00;
  localparam logic [7:0]  PORT1_ADDR       = 8'h01;
  localparam logic [7:0]  PORT2_ADDR       = 8'h02;
  localparam logic [7:0]  PORT3_ADDR       = 8'h03;
  localparam logic [7:0]  GPR_FIRST        = 8'h04;
  localparam logic [7:0]  GPR_LAST         = 8'hBF;
  localparam logic [7:0]  CTRL_FIRST       = 8'hF0;
  localparam logic [7:0]  P2DIR_ADDR       = 8'hF6;
  localparam logic [7:0]  IRQ_EN_ADDR      = 8'hF7;
  localparam logic [7:0]  RP_ADDR          = 8'hFD;
  localparam int          GPR_COUNT        = 188;
  localparam int          WORK_GROUPS      = 9;
  localparam logic [7:0]  PORT_OUT_RESET   = 8'hFF;
  localparam logic [7:0]  P2DIR_RESET      = 8'hF0;
  localparam logic [7:0]  RP_RESET         = 8'h00;
  localparam logic [15:0] VECTOR_BYTES     = 16'h000C;
  localparam logic [15:0] ROM_TOP_LARGE    = 16'h0FFF;
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          REQ_HIGH_MIN_TPC = 3;
  localparam int          REQ_HIGH_MIN_CYC =
    (REQ_HIGH_MIN_TPC * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- core/port_register_file_map.sv ----
// Purpose: Port registers, register file decode and program map checks.
// Assumes: Core drives one read or write per cycle; reads answer next cycle.
// Notes:   Only the port-facing control registers and the register pointer live here.
// What this block does
// RULE1: First port: eight open-drain output bits.
// RULE2: Second port: eight more open-drain outputs.
// RULE3: Third port: four inputs, four programmable bidirectional.
// RULE4: Fourth port: four inputs, four LED outputs.
// RULE5: Fourth port inputs act as four interrupts.
// RULE6: Requesters hold lines high three clocks minimum.
// RULE7: Sixteen-bit program counter, four KB space.
// RULE8: Lowest twelve bytes hold six vectors.
// RULE9: ROM from byte twelve to top; rest reserved.
// RULE10: Ports 0-3, general 4-191, control 240-255.
// RULE11: Eight-bit direct or indirect register addressing.
// RULE12: Short address is pointer group plus offset.
// RULE13: Locations 192-239 ignore writes, read undefined.
`timescale 1ns/1ps
`default_nettype none
module port_register_file_map #(
  parameter logic [15:0] ROM_TOP = port_regfile_pkg::ROM_TOP_LARGE
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        short_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [15:0] pc_i,
  output logic             pc_vector_o,
  output logic             pc_rom_o,
  output logic             pc_reserved_o,
  output logic [7:0]       first_output_port_bits_oe_o,
  output logic [7:0]       second_output_port_bits_oe_o,
  input  wire logic [7:0]  mixed_direction_port_bits_i,
  output logic [7:0]       mixed_direction_port_bits_o,
  output logic [7:0]       mixed_direction_port_bits_oe_o,
  input  wire logic [3:0]  interrupt_capable_input_bits_i,
  output logic [3:0]       led_drive_output_bits_o,
  output logic [3:0]       external_interrupt_requests_o
);
  logic [7:0]  port0_reg;
  logic [7:0]  port1_reg;
  logic [7:0]  port2_reg;
  logic [7:0]  port3_reg;
  logic [7:0]  p2dir_reg;
  logic [3:0]  irq_en_reg;
  logic [7:0]  rp_reg;
  logic [7:0]  p2_meta_reg;
  logic [7:0]  p2_sync_reg;
  logic [3:0]  p3_meta_reg;
  logic [3:0]  p3_sync_reg;
  logic [3:0]  p3_prev_reg;
  logic [7:0]  eff_addr;
  logic        gpr_hit;
  logic [7:0]  gpr_idx;
  logic [7:0]  gpr_rdata;
  logic        gpr_sel_reg;
  logic [7:0]  fast_rdata_reg;
  logic [7:0]  fast_rdata_next;
  logic        wr_port0;
  logic        wr_port1;
  logic        wr_port2;
  logic        wr_port3;
  logic        wr_dir;
  logic        wr_irq_en;
  logic        wr_ptr;
  logic [7:0]  gpr_raddr;
  logic [7:0]  gpr_raddr_reg;

  // RULE12: pointer plus offset.
  // RULE11: full eight-bit address.
  always_comb begin
    if (short_i) begin
      eff_addr = {rp_reg[7:4], addr_i[3:0]};
    end else begin
      eff_addr = addr_i;
    end
  end

  // RULE10: general register window.
  assign gpr_hit = (eff_addr >= port_regfile_pkg::GPR_FIRST) &&
                   (eff_addr <= port_regfile_pkg::GPR_LAST);
  assign gpr_idx = eff_addr - port_regfile_pkg::GPR_FIRST;

  // The memory reads on every edge, so its address is held between
  // reads; read data then stands until the next read, though a write
  // to the held location shows through.
  assign gpr_raddr = rd_i ? gpr_idx : gpr_raddr_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gpr_raddr_reg <= 8'h00;
    end else if (rd_i) begin
      gpr_raddr_reg <= gpr_idx;
    end
  end

  gpr_mem #(
    .DEPTH (port_regfile_pkg::GPR_COUNT),
    .AW    (8)
  ) u_gpr_mem (
    .clk_i   (clk_i),
    .we_i    (wr_i && gpr_hit),
    .waddr_i (gpr_idx),
    .wdata_i (wdata_i),
    .raddr_i (gpr_raddr),
    .rdata_o (gpr_rdata)
  );

  // Pin inputs pass two flip-flops; only the second stage is read.
  always_ff @(posedge clk_i) begin
    p2_meta_reg <= mixed_direction_port_bits_i;
    p2_sync_reg <= p2_meta_reg;
  end

  always_ff @(posedge clk_i) begin
    p3_meta_reg <= interrupt_capable_input_bits_i;
    p3_sync_reg <= p3_meta_reg;
  end

  // RULE10: register decode.
  // RULE13: unimplemented range ignored.
  // Locations 192-239 and unused control slots match no strobe.
  always_comb begin
    wr_port0  = 1'b0;
    wr_port1  = 1'b0;
    wr_port2  = 1'b0;
    wr_port3  = 1'b0;
    wr_dir    = 1'b0;
    wr_irq_en = 1'b0;
    wr_ptr    = 1'b0;
    if (wr_i) begin
      if (eff_addr == port_regfile_pkg::PORT0_ADDR) begin
        wr_port0 = 1'b1;
      end else if (eff_addr == port_regfile_pkg::PORT1_ADDR) begin
        wr_port1 = 1'b1;
      end else if (eff_addr == port_regfile_pkg::PORT2_ADDR) begin
        wr_port2 = 1'b1;
      end else if (eff_addr == port_regfile_pkg::PORT3_ADDR) begin
        wr_port3 = 1'b1;
      end else if (eff_addr == port_regfile_pkg::P2DIR_ADDR) begin
        wr_dir = 1'b1;
      end else if (eff_addr == port_regfile_pkg::IRQ_EN_ADDR) begin
        wr_irq_en = 1'b1;
      end else if (eff_addr == port_regfile_pkg::RP_ADDR) begin
        wr_ptr = 1'b1;
      end
    end
  end

  // RULE1: first port latch.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port0_reg <= port_regfile_pkg::PORT_OUT_RESET;
    end else if (wr_port0) begin
      port0_reg <= wdata_i;
    end
  end

  // RULE2: second port latch.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port1_reg <= port_regfile_pkg::PORT_OUT_RESET;
    end else if (wr_port1) begin
      port1_reg <= wdata_i;
    end
  end

  // RULE3: mixed port latch.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port2_reg <= port_regfile_pkg::PORT_OUT_RESET;
    end else if (wr_port2) begin
      port2_reg <= wdata_i;
    end
  end

  // RULE4: LED output latch.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port3_reg <= port_regfile_pkg::PORT_OUT_RESET;
    end else if (wr_port3) begin
      port3_reg <= wdata_i;
    end
  end

  // RULE3: direction select.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      p2dir_reg <= port_regfile_pkg::P2DIR_RESET;
    end else if (wr_dir) begin
      p2dir_reg <= wdata_i;
    end
  end

  // RULE5: interrupt enable.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en_reg <= 4'h0;
    end else if (wr_irq_en) begin
      irq_en_reg <= wdata_i[3:0];
    end
  end

  // RULE12: pointer register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rp_reg <= port_regfile_pkg::RP_RESET;
    end else if (wr_ptr) begin
      rp_reg <= wdata_i;
    end
  end

  // Open drain: a zero in the latch pulls the pin, a one releases it.
  // RULE1: drive low only.
  assign first_output_port_bits_oe_o  = ~port0_reg;
  // RULE2: drive low only.
  assign second_output_port_bits_oe_o = ~port1_reg;

  // RULE3: low nibble fixed input.
  assign mixed_direction_port_bits_o    = port2_reg;
  assign mixed_direction_port_bits_oe_o = {~p2dir_reg[7:4], 4'h0};

  // RULE4: fixed outputs.
  assign led_drive_output_bits_o = port3_reg[7:4];

  // RULE5: rising edge requests.
  // RULE6: depends on width.
  // A request shorter than one clock period may be missed, hence
  // the minimum high time placed on the requester.
  // History follows the pin during reset, so a line already high when
  // reset ends is not taken as a fresh request.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      p3_prev_reg                   <= p3_sync_reg;
      external_interrupt_requests_o <= 4'h0;
    end else begin
      p3_prev_reg                   <= p3_sync_reg;
      external_interrupt_requests_o <= irq_en_reg & p3_sync_reg &
                                       ~p3_prev_reg;
    end
  end

  // RULE13: undefined read is zero.
  always_comb begin
    fast_rdata_next = 8'h00;
    if (eff_addr == port_regfile_pkg::PORT0_ADDR) begin
      fast_rdata_next = port0_reg;
    end else if (eff_addr == port_regfile_pkg::PORT1_ADDR) begin
      fast_rdata_next = port1_reg;
    end else if (eff_addr == port_regfile_pkg::PORT2_ADDR) begin
      fast_rdata_next = {(p2dir_reg[7:4] & p2_sync_reg[7:4]) |
                         (~p2dir_reg[7:4] & port2_reg[7:4]),
                         p2_sync_reg[3:0]};
    end else if (eff_addr == port_regfile_pkg::PORT3_ADDR) begin
      fast_rdata_next = {port3_reg[7:4], p3_sync_reg};
    end else if (eff_addr == port_regfile_pkg::P2DIR_ADDR) begin
      fast_rdata_next = p2dir_reg;
    end else if (eff_addr == port_regfile_pkg::IRQ_EN_ADDR) begin
      fast_rdata_next = {4'h0, irq_en_reg};
    end else if (eff_addr == port_regfile_pkg::RP_ADDR) begin
      fast_rdata_next = rp_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fast_rdata_reg <= 8'h00;
    end else if (rd_i) begin
      fast_rdata_reg <= fast_rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gpr_sel_reg <= 1'b0;
    end else if (rd_i) begin
      gpr_sel_reg <= gpr_hit;
    end
  end

  assign rdata_o = gpr_sel_reg ? gpr_rdata : fast_rdata_reg;

  // RULE8: vector area.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_vector_o <= 1'b1;
    end else begin
      pc_vector_o <= pc_i < port_regfile_pkg::VECTOR_BYTES;
    end
  end

  // RULE9: ROM from byte twelve to top.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_rom_o <= 1'b0;
    end else begin
      pc_rom_o <= (pc_i >= port_regfile_pkg::VECTOR_BYTES) &&
                  (pc_i <= ROM_TOP);
    end
  end

  // RULE7: sixteen-bit counter space.
  // RULE9: above the top is reserved.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_reserved_o <= 1'b0;
    end else begin
      pc_reserved_o <= pc_i > ROM_TOP;
    end
  end
endmodule
`default_nettype wire

// ---- tb/kbd_far_side.sv ----
// Purpose: Keyboard side of the mixed port and the request lines.
// Assumes: Pull-ups hold undriven mixed pins high.
// Notes:   A raise command holds a line high for four clocks.
`timescale 1ns/1ps
`default_nettype none
module kbd_far_side (
  input  wire logic       clk_i,
  input  wire logic [3:0] press_i,
  input  wire logic [3:0] raise_i,
  input  wire logic [7:0] mix_drv_i,
  input  wire logic [7:0] mix_oe_i,
  output logic      [7:0] mix_pin_o,
  output logic      [3:0] req_line_o
);
  logic [2:0] left [4] = '{default: 3'h0};
  assign mix_pin_o = {mix_drv_i[7:4] | ~mix_oe_i[7:4], press_i};
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (raise_i[i]) left[i] <= 3'h4;
      else if (left[i] != 3'h0) left[i] <= left[i] - 3'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) req_line_o[i] = (left[i] != 3'h0);
  end
endmodule
`default_nettype wire

// ---- tb/port_map_assertions.sv ----
// Purpose: Port, decode and program map checks on the top module.
// Assumes: Synchronous active-high reset, one clock.
// Notes:   Interrupt check allows for the two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
module port_map_assertions #(
  parameter logic [15:0] ROM_TOP = 16'h0FFF
) (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        wr_i,
  input wire logic        short_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [15:0] pc_i,
  input wire logic        pc_vector_o,
  input wire logic        pc_rom_o,
  input wire logic        pc_reserved_o,
  input wire logic [7:0]  first_output_port_bits_oe_o,
  input wire logic [7:0]  mixed_direction_port_bits_oe_o,
  input wire logic [3:0]  interrupt_capable_input_bits_i,
  input wire logic [3:0]  led_drive_output_bits_o,
  input wire logic [3:0]  external_interrupt_requests_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_port0;
    wr_i && !short_i && addr_i == 8'h00
    |=> first_output_port_bits_oe_o == ~$past(wdata_i);
  endproperty
  a_port0: assert property (p_port0)
    else $error("first port enable mismatch");
  property p_mix_in;
    mixed_direction_port_bits_oe_o[3:0] == 4'h0;
  endproperty
  a_mix_in: assert property (p_mix_in)
    else $error("fixed input bit driven");
  property p_mix_dir;
    wr_i && !short_i && addr_i == 8'hF6
    |=> mixed_direction_port_bits_oe_o == {~$past(wdata_i[7:4]), 4'h0};
  endproperty
  a_mix_dir: assert property (p_mix_dir)
    else $error("direction enable mismatch");
  property p_led;
    wr_i && !short_i && addr_i == 8'h03
    |=> led_drive_output_bits_o == $past(wdata_i[7:4]);
  endproperty
  a_led: assert property (p_led)
    else $error("led bits mismatch");
  property p_irq;
    |external_interrupt_requests_o
    |-> (($past(interrupt_capable_input_bits_i, 2)
    & external_interrupt_requests_o) == external_interrupt_requests_o)
    ##1 external_interrupt_requests_o == 4'h0;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request pulse without input");
  property p_vec;
    pc_i < 16'h000C |=> pc_vector_o && !pc_rom_o;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector class wrong");
  property p_rom;
    pc_i >= 16'h000C && pc_i <= ROM_TOP |=> pc_rom_o && !pc_reserved_o;
  endproperty
  a_rom: assert property (p_rom)
    else $error("rom class wrong");
  property p_res;
    pc_i > ROM_TOP |=> pc_reserved_o && !pc_vector_o;
  endproperty
  a_res: assert property (p_res)
    else $error("reserved class wrong");
  property p_gap;
    wr_i && !short_i && addr_i >= 8'hC0 && addr_i <= 8'hEF
    |=> $stable(first_output_port_bits_oe_o) &&
        $stable(led_drive_output_bits_o);
  endproperty
  a_gap: assert property (p_gap)
    else $error("unimplemented write took effect");
endmodule
bind port_register_file_map port_map_assertions #(.ROM_TOP(ROM_TOP)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .wr_i(wr_i), .short_i(short_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .pc_i(pc_i),
  .pc_vector_o(pc_vector_o), .pc_rom_o(pc_rom_o),
  .pc_reserved_o(pc_reserved_o),
  .first_output_port_bits_oe_o(first_output_port_bits_oe_o),
  .mixed_direction_port_bits_oe_o(mixed_direction_port_bits_oe_o),
  .interrupt_capable_input_bits_i(interrupt_capable_input_bits_i),
  .led_drive_output_bits_o(led_drive_output_bits_o),
  .external_interrupt_requests_o(external_interrupt_requests_o));
`default_nettype wire

// ---- tb/tb_port_register_file_map.sv ----
// Purpose: Self-checking bench for the port and register file block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Each scenario judges its own results.
`timescale 1ns/1ps
`default_nettype none
module tb_port_register_file_map;
  logic clk_i = 1'b0, srst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0, short_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, oe0, oe1, mo, moe, mi;
  logic [15:0] pc_i = 16'h0000;
  logic pv, pr, px;
  logic [3:0] press = 4'h0, raise = 4'h0, req, led, ext;
  logic [7:0] d;
  int n_errors = 0, n_tests = 0;
  always #50 clk_i = ~clk_i;
  port_register_file_map u_port_register_file_map (.clk_i(clk_i),
    .srst_i(srst_i), .rd_i(rd_i), .wr_i(wr_i), .short_i(short_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .pc_i(pc_i),
    .pc_vector_o(pv), .pc_rom_o(pr), .pc_reserved_o(px),
    .first_output_port_bits_oe_o(oe0), .second_output_port_bits_oe_o(oe1),
    .mixed_direction_port_bits_i(mi), .mixed_direction_port_bits_o(mo),
    .mixed_direction_port_bits_oe_o(moe),
    .interrupt_capable_input_bits_i(req), .led_drive_output_bits_o(led),
    .external_interrupt_requests_o(ext));
  kbd_far_side u_kbd_far_side (.clk_i(clk_i), .press_i(press),
    .raise_i(raise), .mix_drv_i(mo), .mix_oe_i(moe), .mix_pin_o(mi),
    .req_line_o(req));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic s);
    @(negedge clk_i);
    {wr_i, addr_i, wdata_i, short_i} = {1'b1, a, v, s};
    @(negedge clk_i);
    {wr_i, short_i} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_i);
    {rd_i, addr_i} = {1'b1, a};
    @(negedge clk_i);
    rd_i = 1'b0;
    v = rdata_o;
  endtask
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_outs();
    chk(oe0, 8'h00);
    chk({4'h0, led}, 8'h0F);
    wr(8'h00, 8'hA5, 1'b0);
    wr(8'h01, 8'h3C, 1'b0);
    wr(8'h03, 8'h50, 1'b0);
    chk(oe0, 8'h5A);
    chk(oe1, 8'hC3);
    chk({4'h0, led}, 8'h05);
    rd(8'h00, d);
    chk(d, 8'hA5);
    $display("t_outs done");
  endtask
  task automatic t_mixed();
    press = 4'h5;
    wr(8'hF6, 8'h00, 1'b0);
    wr(8'h02, 8'h9A, 1'b0);
    chk(mo, 8'h9A);
    chk(moe, 8'hF0);
    repeat (3) @(negedge clk_i);
    rd(8'h02, d);
    chk(d, 8'h95);
    wr(8'hF6, 8'hF0, 1'b0);
    chk(moe, 8'h00);
    $display("t_mixed done");
  endtask
  task automatic t_regs();
    wr(8'h04, 8'h11, 1'b0);
    wr(8'hBF, 8'h22, 1'b0);
    rd(8'h04, d);
    chk(d, 8'h11);
    rd(8'hBF, d);
    chk(d, 8'h22);
    wr(8'hFD, 8'h10, 1'b0);
    chk(rdata_o, 8'h22);
    wr(8'h05, 8'h6B, 1'b1);
    rd(8'h15, d);
    chk(d, 8'h6B);
    wr(8'hC0, 8'h77, 1'b0);
    rd(8'hC0, d);
    chk(d, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_irq();
    int i;
    logic [3:0] seen;
    wr(8'hF7, 8'h0F, 1'b0);
    @(negedge clk_i) raise = 4'h4;
    @(negedge clk_i) raise = 4'h0;
    for (i = 0; i < 10 && ext === 4'h0; i++) @(negedge clk_i);
    chk({4'h0, ext}, 8'h04);
    if (ext === 4'h0) tally_and_finish();
    wr(8'hF7, 8'h00, 1'b0);
    seen = 4'h0;
    @(negedge clk_i) raise = 4'h1;
    @(negedge clk_i) raise = 4'h0;
    for (i = 0; i < 10; i++) @(negedge clk_i) seen = seen | ext;
    chk({4'h0, seen}, 8'h00);
    $display("t_irq done");
  endtask
  task automatic t_pc();
    logic [15:0] pcs [6];
    logic [2:0] cls [6];
    pcs = '{16'h0000, 16'h000B, 16'h000C, 16'h0FFF, 16'h1000, 16'hFFFF};
    cls = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
    for (int k = 0; k < 6; k++) begin
      @(negedge clk_i) pc_i = pcs[k];
      @(negedge clk_i) chk({5'h00, pv, pr, px}, {5'h00, cls[k]});
    end
    $display("t_pc done");
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    t_outs();
    t_mixed();
    t_regs();
    t_irq();
    t_pc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
